// [include/rsa_pkg.sv]
package rsa_pkg;
    // Register map and field layout
    localparam logic [7:0] RSA_ASSIGN_ADDR = 8'h23;
    localparam logic [7:0] RSA_ASSIGN_RST = 8'h45;
    localparam int RSA_R4_LSB = 4;
    localparam int RSA_R3_LSB = 0;
    localparam int RSA_CODE_W = 4;
    // Strobe code range under sequencer control
    localparam logic [3:0] RSA_CODE_MIN = 4'h3;
    localparam logic [3:0] RSA_CODE_MAX = 4'ha;
    localparam logic [3:0] RSA_LAST_STROBE = 4'ha;
    localparam logic [3:0] RSA_FIRST_STROBE = 4'h1;
    // Inter-strobe delays
    localparam int RSA_CLK_HZ = 40000000;
    localparam int RSA_DLY_SHORT_MS = 2;
    localparam int RSA_DLY_LONG_MS = 5;
    localparam int RSA_DLY_FACTOR = 10;
    localparam int RSA_DLY_SHORT_CYC = RSA_CLK_HZ / 1000 * RSA_DLY_SHORT_MS;
    localparam int RSA_DLY_LONG_CYC = RSA_CLK_HZ / 1000 * RSA_DLY_LONG_MS;
    localparam int RSA_GAPS = 9;
    localparam int RSA_CNT_W = 24;
    typedef enum logic [2:0] {
        RSA_IDLE = 3'b001,
        RSA_UP = 3'b010,
        RSA_DOWN = 3'b100
    } rsa_state_e;
endpackage

// [src/rsa_seq.sv]
`timescale 1ns/1ps
module rsa_seq
    import rsa_pkg::*;
#(
    parameter int SHORT_CYC = RSA_DLY_SHORT_CYC,
    parameter int LONG_CYC = RSA_DLY_LONG_CYC
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [8:0] gap_long_i,
    input wire logic powerdown_delay_factor_i,
    input wire logic power_up_i,
    input wire logic power_down_i,
    output logic [3:0] strobe_o,
    output logic seq_busy_o,
    output logic buck_rail_three_en_o,
    output logic buck_boost_rail_four_en_o
);
    import rsa_pkg::*;

    logic [7:0] strobe_assign_byte_r;
    rsa_state_e state_r, state_nxt;
    logic [3:0] strobe_r, strobe_nxt;
    logic [RSA_CNT_W-1:0] cnt_r, cnt_nxt;
    logic r3_en_r, r4_en_r;
    logic [3:0] rail3_strobe_select, rail4_strobe_select;
    logic r3_ctl, r4_ctl, sel_wr, cnt_done, gap_long;
    logic [RSA_CNT_W-1:0] gap_cyc, gap_base;
    logic [3:0] gap_idx;

    // Register decode and field split
    assign sel_wr = reg_wr_i && (reg_addr_i == RSA_ASSIGN_ADDR);
    assign reg_rdata_o = (reg_addr_i == RSA_ASSIGN_ADDR) ?
        strobe_assign_byte_r : 8'h00;
    assign rail4_strobe_select =
        strobe_assign_byte_r[RSA_R4_LSB +: RSA_CODE_W];
    assign rail3_strobe_select =
        strobe_assign_byte_r[RSA_R3_LSB +: RSA_CODE_W];
    // Controlled only for codes 3h..Ah
    assign r3_ctl = (rail3_strobe_select >= RSA_CODE_MIN) &&
        (rail3_strobe_select <= RSA_CODE_MAX);
    assign r4_ctl = (rail4_strobe_select >= RSA_CODE_MIN) &&
        (rail4_strobe_select <= RSA_CODE_MAX);

    // Gap index: gap k lies between strobe k and k+1
    assign gap_idx = (state_r == RSA_DOWN) ? strobe_r - 4'h1 : strobe_r;
    assign gap_long = (gap_idx >= RSA_FIRST_STROBE) &&
        (gap_idx <= 4'h9) ? gap_long_i[gap_idx - 4'h1] : 1'b0;
    assign gap_base = gap_long ? RSA_CNT_W'(LONG_CYC) :
        RSA_CNT_W'(SHORT_CYC);
    assign gap_cyc = (state_r == RSA_DOWN && powerdown_delay_factor_i) ?
        RSA_CNT_W'(gap_base * RSA_DLY_FACTOR) : gap_base;
    assign cnt_done = (cnt_r == RSA_CNT_W'(1));

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        strobe_nxt = strobe_r;
        cnt_nxt = cnt_r;
        case (state_r)
            RSA_IDLE: begin
                if (power_up_i) begin
                    state_nxt = RSA_UP;
                    strobe_nxt = RSA_FIRST_STROBE;
                    cnt_nxt = RSA_CNT_W'(1);
                end else if (power_down_i) begin
                    state_nxt = RSA_DOWN;
                    strobe_nxt = RSA_LAST_STROBE;
                    cnt_nxt = RSA_CNT_W'(1);
                end
            end
            RSA_UP: begin
                if (cnt_done) begin
                    if (strobe_r == RSA_LAST_STROBE) begin
                        state_nxt = RSA_IDLE;
                        strobe_nxt = 4'h0;
                    end else begin
                        strobe_nxt = strobe_r + 4'h1;
                        cnt_nxt = gap_cyc;
                    end
                end else begin
                    cnt_nxt = cnt_r - RSA_CNT_W'(1);
                end
            end
            RSA_DOWN: begin
                if (cnt_done) begin
                    if (strobe_r == RSA_FIRST_STROBE) begin
                        state_nxt = RSA_IDLE;
                        strobe_nxt = 4'h0;
                    end else begin
                        strobe_nxt = strobe_r - 4'h1;
                        cnt_nxt = gap_cyc;
                    end
                end else begin
                    cnt_nxt = cnt_r - RSA_CNT_W'(1);
                end
            end
            default: begin
                state_nxt = RSA_IDLE;
                strobe_nxt = 4'h0;
                cnt_nxt = '0;
            end
        endcase
    end

    // Register and sequencer state
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            strobe_assign_byte_r <= RSA_ASSIGN_RST;
            state_r <= RSA_IDLE;
            strobe_r <= 4'h0;
            cnt_r <= '0;
        end else begin
            if (sel_wr) begin
                strobe_assign_byte_r <= reg_wdata_i;
            end
            state_r <= state_nxt;
            strobe_r <= strobe_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Rail enables at their strobe
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            r3_en_r <= 1'b0;
            r4_en_r <= 1'b0;
        end else if (cnt_done && strobe_r != 4'h0) begin
            if (r3_ctl && strobe_r == rail3_strobe_select) begin
                r3_en_r <= (state_r == RSA_UP);
            end
            if (r4_ctl && strobe_r == rail4_strobe_select) begin
                r4_en_r <= (state_r == RSA_UP);
            end
        end
    end

    assign strobe_o = strobe_r;
    assign seq_busy_o = (state_r != RSA_IDLE);
    assign buck_rail_three_en_o = r3_en_r;
    assign buck_boost_rail_four_en_o = r4_en_r;

    // Checks
    sequence s_strobe_hit3;
        cnt_done && state_r == RSA_UP && r3_ctl &&
            strobe_r == rail3_strobe_select;
    endsequence
    sequence s_strobe_hit4;
        cnt_done && state_r == RSA_UP && r4_ctl &&
            strobe_r == rail4_strobe_select;
    endsequence
    rail4_enable_a: assert property (@(posedge ref_clk_i)
        disable iff (srst_i) s_strobe_hit4 |=> r4_en_r)
        else $error("rail four missed its strobe");
    reset_value_a: assert property (@(posedge ref_clk_i)
        $past(srst_i) |-> strobe_assign_byte_r == 8'h45)
        else $error("assignment byte reset value wrong");
    write_field_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        sel_wr |=> rail4_strobe_select == $past(reg_wdata_i[7:4]) &&
            rail3_strobe_select == $past(reg_wdata_i[3:0]))
        else $error("fields not written");
    readback_a: assert property (@(posedge ref_clk_i)
        reg_addr_i == 8'h23 |-> reg_rdata_o[3:0] == rail3_strobe_select)
        else $error("rail three readback wrong");
    low_code_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        rail3_strobe_select <= 4'h2 && !r3_en_r |=> !r3_en_r)
        else $error("low code rail enabled");
    strobe_enable_a: assert property (@(posedge ref_clk_i)
        disable iff (srst_i) s_strobe_hit3 |=> r3_en_r)
        else $error("rail three missed its strobe");
    high_code_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        rail4_strobe_select >= 4'hb && !r4_en_r |=> !r4_en_r)
        else $error("high code rail enabled");
    gap_load_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        state_r == RSA_UP && cnt_done && strobe_r != 4'ha |=>
            cnt_r == $past(gap_base))
        else $error("power-up gap not plain delay");
    down_order_a: assert property (@(posedge ref_clk_i) disable iff (srst_i)
        state_r == RSA_DOWN && cnt_done && strobe_r != 4'h1 |=>
            strobe_r == $past(strobe_r) - 4'h1)
        else $error("power-down order not reversed");
endmodule

// [sim/tb.sv]
`timescale 1ns/1ps
module tb;
    import rsa_pkg::*;
    localparam int SC = 4;
    localparam int LC = 10;
    logic ref_clk_i = 0, srst_i = 1, reg_wr_i = 0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
    logic [8:0] gap_long_i = 9'h0a5;
    logic powerdown_delay_factor_i = 0, power_up_i = 0, power_down_i = 0;
    logic [3:0] strobe_o, oc [8];
    logic seq_busy_o, buck_rail_three_en_o, buck_boost_rail_four_en_o;
    int failures = 0, samples_checked = 0, c;
    rsa_seq #(.SHORT_CYC(SC), .LONG_CYC(LC)) u_rsa_seq (
        .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .gap_long_i(gap_long_i),
        .powerdown_delay_factor_i(powerdown_delay_factor_i),
        .power_up_i(power_up_i), .power_down_i(power_down_i),
        .strobe_o(strobe_o), .seq_busy_o(seq_busy_o),
        .buck_rail_three_en_o(buck_rail_three_en_o),
        .buck_boost_rail_four_en_o(buck_boost_rail_four_en_o));
    // Clock at 40 MHz
    initial forever #12.5 ref_clk_i = ~ref_clk_i;
    task automatic end_sim;
        if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1;
        @(negedge ref_clk_i);
        reg_wr_i = 0;
    endtask
    task automatic rd(input string nm, input logic [7:0] a, e);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        #1 chk(nm, e, reg_rdata_o);
    endtask
    // One full sequence, checking order, slot lengths and enable moments
    task automatic run_seq(input logic up, input logic [3:0] c3, c4);
        logic [3:0] p, q;
        logic [7:0] x;
        logic e3, e4;
        int n, k, g;
        e3 = buck_rail_three_en_o;
        e4 = buck_boost_rail_four_en_o;
        @(negedge ref_clk_i);
        if (up) power_up_i = 1;
        else power_down_i = 1;
        @(negedge ref_clk_i);
        power_up_i = 0;
        power_down_i = 0;
        chk("first strobe", up ? 8'h01 : 8'h0a, {4'h0, strobe_o});
        p = strobe_o;
        n = 1;
        for (k = 0; k < 5000 && seq_busy_o === 1'b1; k++) begin
            @(negedge ref_clk_i);
            power_down_i = up && k == 2;
            q = p;
            if (strobe_o === p) n++;
            else begin
                // Up: slot p lasts gap p-1; down: slot p lasts gap p
                if (up ? p > 4'h1 : p < 4'ha) begin
                    g = gap_long_i[up ? p - 4'h2 : p - 4'h1] ? LC : SC;
                    if (!up && powerdown_delay_factor_i) g = g * 10;
                    chk("slot length", 8'(g), 8'(n));
                end
                x = up ? (p == 4'ha ? 8'h00 : 8'(p + 4'h1)) : 8'(p - 4'h1);
                chk("next strobe", x, {4'h0, strobe_o});
                p = strobe_o;
                n = 1;
            end
            // Enables change at the end of the slot that just closed
            if (buck_rail_three_en_o !== e3)
                chk("rail3 slot", {4'h0, c3}, {4'h0, q});
            if (buck_boost_rail_four_en_o !== e4)
                chk("rail4 slot", {4'h0, c4}, {4'h0, q});
            e3 = buck_rail_three_en_o;
            e4 = buck_boost_rail_four_en_o;
        end
        chk("busy end", 8'h00, {7'h0, seq_busy_o});
        x = {7'h0, up && c3 >= 4'h3 && c3 <= 4'ha};
        chk("rail3 end", x, {7'h0, e3});
        x = {7'h0, up && c4 >= 4'h3 && c4 <= 4'ha};
        chk("rail4 end", x, {7'h0, e4});
    endtask
    // Watchdog
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        failures++;
        end_sim;
    end
    // Main sequence
    initial begin
        oc = '{4'h0, 4'h1, 4'h2, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
        repeat (10) @(negedge ref_clk_i);
        srst_i = 0;
        rd("reset byte", RSA_ASSIGN_ADDR, 8'h45);
        rd("other address", 8'h22, 8'h00);
        wr(8'h24, 8'hff);
        rd("after stray write", RSA_ASSIGN_ADDR, 8'h45);
        for (c = 3; c <= 10; c++) begin
            wr(RSA_ASSIGN_ADDR, {4'(13 - c), 4'(c)});
            rd("byte readback", RSA_ASSIGN_ADDR, {4'(13 - c), 4'(c)});
            powerdown_delay_factor_i = c[0];
            run_seq(1'b1, 4'(c), 4'(13 - c));
            run_seq(1'b0, 4'(c), 4'(13 - c));
        end
        for (c = 0; c < 8; c++) begin
            wr(RSA_ASSIGN_ADDR, {oc[7 - c], oc[c]});
            run_seq(1'b1, oc[c], oc[7 - c]);
        end
        end_sim;
    end
endmodule
